// ---- hdl/ow_link_regs.svh ----
// constants of the single-wire flow link: timing, commands, result map, host registers
`ifndef OW_LINK_REGS_SVH
`define OW_LINK_REGS_SVH

// ==========================================================
// clock and link timing, times in microseconds
`define OW_MCLK_MHZ              40
`define OW_T_SLOT_US             60
`define OW_T_SAMPLE_US           20
`define OW_T_READ_MAX_US         10
`define OW_T_BUS_RST_MIN_US      400
`define OW_T_PRES_WAIT_US        30
`define OW_T_PRES_LOW_US         120
`define OW_T_HOST_RST_US         480
`define OW_T_HOST_PRES_SAMPLE_US 70
`define OW_T_WR_LOW_US           3
`define OW_T_RD_LOW_US           4
`define OW_T_RD_SAMPLE_US        11
`define OW_T_GAP_US              2

// ==========================================================
// timing in clock cycles
`define OW_SLOT_CYC       16'(`OW_T_SLOT_US * `OW_MCLK_MHZ)
`define OW_SAMPLE_CYC     16'(`OW_T_SAMPLE_US * `OW_MCLK_MHZ)
`define OW_READ_MAX_CYC   16'(`OW_T_READ_MAX_US * `OW_MCLK_MHZ)
`define OW_BUS_RST_CYC    16'(`OW_T_BUS_RST_MIN_US * `OW_MCLK_MHZ)
`define OW_PRES_WAIT_CYC  16'(`OW_T_PRES_WAIT_US * `OW_MCLK_MHZ)
`define OW_PRES_LOW_CYC   16'(`OW_T_PRES_LOW_US * `OW_MCLK_MHZ)
`define OW_HOST_RST_CYC   16'(`OW_T_HOST_RST_US * `OW_MCLK_MHZ)
`define OW_HOST_PRES_CYC  16'(`OW_T_HOST_PRES_SAMPLE_US * `OW_MCLK_MHZ)
`define OW_WR_LOW_CYC     16'(`OW_T_WR_LOW_US * `OW_MCLK_MHZ)
`define OW_RD_LOW_CYC     16'(`OW_T_RD_LOW_US * `OW_MCLK_MHZ)
`define OW_RD_SAMPLE_CYC  16'(`OW_T_RD_SAMPLE_US * `OW_MCLK_MHZ)
`define OW_GAP_CYC        16'(`OW_T_GAP_US * `OW_MCLK_MHZ)

// ==========================================================
// command bytes
`define OW_CMD_CLEAR  8'h5a
`define OW_CMD_READ   8'h5b
`define OW_CMD_RESET  8'h5d
`define OW_CMD_BARE   8'haa

// ==========================================================
// result map
`define OW_INST_FLOW_BYTE0   8'h30
`define OW_INST_FLOW_BYTE1   8'h31
`define OW_INST_FLOW_BYTE2   8'h32
`define OW_INST_FLOW_CHECK   8'h33
`define OW_WATER_TEMP_BYTE0  8'h34
`define OW_WATER_TEMP_BYTE1  8'h35
`define OW_WATER_TEMP_BYTE2  8'h36
`define OW_WATER_TEMP_CHECK  8'h37
`define OW_TOTAL_FLOW_BYTE0  8'h38
`define OW_TOTAL_FLOW_BYTE1  8'h39
`define OW_TOTAL_FLOW_BYTE2  8'h3a
`define OW_TOTAL_FLOW_CHECK  8'h3b
`define OW_CRC_POLY          8'h31
`define OW_CRC_INIT          8'hff

// ==========================================================
// host controller registers on apb
`define OW_APB_CMD        8'h00
`define OW_APB_STATUS     8'h04
`define OW_APB_RXDATA     8'h08
`define OW_CMD_OP_LSB     0
`define OW_CMD_DATA_LSB   8
`define OW_STAT_BUSY_BIT  0
`define OW_STAT_PRES_BIT  1

`endif

// ---- hdl/ow_link_pkg.sv ----
// types and the check byte function of the single-wire flow link
package ow_link_pkg;
   `include "ow_link_regs.svh"

   typedef enum logic [1:0] {
      D_IDLE   = 2'b00,
      D_SLOT   = 2'b01,
      D_PWAIT  = 2'b10,
      D_PDRIVE = 2'b11
   } dev_state_t;

   typedef enum logic [1:0] {
      PH_CMD = 2'b00,
      PH_REG = 2'b01,
      PH_TX  = 2'b10
   } ow_phase_t;

   typedef enum logic [2:0] {
      H_IDLE     = 3'b000,
      H_RST_LOW  = 3'b001,
      H_RST_WAIT = 3'b010,
      H_SLOT     = 3'b011,
      H_GAP      = 3'b100
   } host_state_t;

   typedef enum logic [1:0] {
      OP_NONE  = 2'b00,
      OP_RESET = 2'b01,
      OP_WRITE = 2'b10,
      OP_READ  = 2'b11
   } host_op_t;

   typedef struct packed {
      dev_state_t st;
      logic [15:0] cnt;
      logic [2:0]  bitn;
      logic [7:0]  rx;
      logic [7:0]  tx;
      logic [7:0]  ptr;
      ow_phase_t   ph;
      logic        reduced;
      logic        fresh;
      logic        seen_rise;
      logic        rst_seen;
      logic        oe;
      logic        dq_q;
      logic        clr;
      logic        mrst;
   } dev_reg_t;

   typedef struct packed {
      host_state_t st;
      host_op_t    op;
      logic [15:0] cnt;
      logic [2:0]  bitn;
      logic [7:0]  sh;
      logic [7:0]  rxd;
      logic        presence;
      logic        oe;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } host_reg_t;

   // check byte over three data bytes, low byte fed first, msb first shifting
   function automatic logic [7:0] crc8_3(input logic [23:0] d);
      logic [7:0] c;
      c = `OW_CRC_INIT;
      for (int i = 0; i < 3; i++) begin
         c = c ^ d[8*i +: 8];
         for (int t = 0; t < 8; t++) begin
            c = c[7] ? ({c[6:0], 1'b0} ^ `OW_CRC_POLY) : {c[6:0], 1'b0};
         end
      end
      return c;
   endfunction
endpackage

// ---- hdl/ow_link_if.sv ----
// the single wire between host controller and flow device
`timescale 1ns/10ps
interface ow_link_if;
   logic host_oe;
   logic dev_oe;
   logic dq;

   // open-drain wire with pull-up: low whenever any end drives
   assign dq = ~(host_oe | dev_oe);

   modport device (input dq, output dev_oe);
   modport host   (input dq, output host_oe);
endinterface

// ---- hdl/ow_flow_device.sv ----
// device end of the single-wire flow link: slot timing, command decode, result map
// Notes on behaviour
// [R01] bytes shift least significant bit first
// [R02] data not ready returns zero bytes
// [R03] slave only, about 16.3 kbit/s
// [R04] presence low after reset release, delayed
// [R05] host write slots 60 us, gap
// [R06] host write: short low, bit, hold
// [R07] short host low starts received bit slot
// [R08] sample received bit at 20 us
// [R09] host read: short low, sample early
// [R10] host read slots 60 us, gap
// [R11] drive bit on fall until 60 us
// [R12] rise within 10 us means read slot
// [R13] command, optional parameters, sum checksum; the command byte and the register byte after 5b are decoded here, with no checksum check
// [R14] 5a clears total, 5d resets, 5b reads
// [R15] register pointer stays 30 to 3b
// [R16] bare command behaves like command aa
// [R17] leaving reduced mode needs bus reset
// [R18] reduced mode answers bare reads
// [R19] 30 to 32 instantaneous flow
// [R20] 34 to 36 water temperature
// [R21] 38 to 3a cumulative flow
// [R22] check byte poly 31, init ff
// [R23] check byte covers three bytes below
// [R24] lines only pulled low, open drain
//
// Local design decision: register access over APB.
`timescale 1ns/10ps
`include "ow_link_regs.svh"
module ow_flow_device
   import ow_link_pkg::*;
#(
   parameter logic [15:0] BUS_RST_CYC = `OW_BUS_RST_CYC,
   parameter logic [15:0] PRES_LOW_CYC = `OW_PRES_LOW_CYC
) (
   input  wire logic        MCLK,
   input  wire logic        RST_N,
   ow_link_if.device        link,
   input  wire logic [23:0] FLOW_RATE,
   input  wire logic [23:0] WATER_TEMP,
   input  wire logic [23:0] TOTAL_FLOW,
   input  wire logic        DATA_READY,
   output logic             CLEAR_TOTAL,
   output logic             MODULE_RESET,
   output logic             REDUCED_MODE
);

   // ==========================================================
   // result map lookup

   // byte at a map address; crc position covers the three below it
   function automatic logic [7:0] map_byte(input logic [7:0]  p,
                                           input logic [23:0] f,
                                           input logic [23:0] t,
                                           input logic [23:0] c,
                                           input logic        rdy);
      logic [7:0]  i;
      logic [23:0] w;
      i = p - `OW_INST_FLOW_BYTE0;
      case (i[3:2])
         2'd0:    w = f;                              // [R19]
         2'd1:    w = t;                              // [R20]
         default: w = c;                              // [R21]
      endcase
      if (!rdy) begin
         map_byte = 8'h00;                            // [R02]
      end else if (i[1:0] == 2'd3) begin
         map_byte = crc8_3(w);                        // [R22] [R23]
      end else begin
         map_byte = w[{i[1:0], 3'b000} +: 8];         // low byte at lowest address
      end
   endfunction

   // ==========================================================
   // state

   dev_reg_t   s;
   dev_reg_t   next_s;
   logic       fall;
   logic [7:0] cur_byte;
   logic       bit_ok;
   logic [7:0] rbyte;

   assign fall = s.dq_q & ~link.dq;

   // byte to send: fresh from the map on the first bit, latched after that
   assign cur_byte = (s.bitn == 3'd0) ?
                     map_byte(s.ptr, FLOW_RATE, WATER_TEMP, TOTAL_FLOW, DATA_READY) : s.tx;

   // ==========================================================
   // next state
   always_comb begin
      next_s      = s;
      bit_ok      = 1'b0;
      rbyte       = s.rx;
      next_s.dq_q = link.dq;
      next_s.clr  = 1'b0;
      next_s.mrst = 1'b0;
      case (s.st)
         D_IDLE: begin
            // every slot begins at a host falling edge
            if (fall) begin
               next_s.st        = D_SLOT;                  // [R07]
               next_s.cnt       = 16'd1;
               next_s.seen_rise = 1'b0;
               next_s.rst_seen  = 1'b0;
               next_s.tx        = cur_byte;
               // only a zero bit pulls the line; a one lets the pull-up win
               next_s.oe = (s.ph == PH_TX) & ~cur_byte[s.bitn];  // [R11] [R24] [R01]
            end
         end
         D_SLOT: begin
            if (s.cnt != 16'hffff) begin
               next_s.cnt = s.cnt + 16'd1;
            end
            // early rise tells a read slot from a low that may be a reset
            if (link.dq && s.cnt < `OW_READ_MAX_CYC) begin
               next_s.seen_rise = 1'b1;                    // [R12]
            end
            if (s.ph != PH_TX && s.cnt == `OW_SAMPLE_CYC) begin
               next_s.rx = {link.dq, s.rx[7:1]};           // [R08] [R01]
            end
            // release at the end of the 60 us slot, which sets the bit rate
            if (s.cnt >= `OW_SLOT_CYC - 16'd1) begin
               next_s.oe = 1'b0;                           // [R11] [R03]
            end
            if (s.cnt >= BUS_RST_CYC) begin
               next_s.rst_seen = 1'b1;                     // [R12]
            end
            // slot ends once the line is back high past the slot time
            if (s.cnt >= `OW_SLOT_CYC && link.dq && !s.oe) begin
               if (s.rst_seen) begin
                  next_s.st   = D_PWAIT;                   // [R04]
                  next_s.cnt  = 16'd0;
                  next_s.bitn = 3'd0;
                  next_s.fresh = 1'b1;
                  // two resets with no slot between leave reduced mode
                  if (s.reduced && s.fresh) begin
                     next_s.reduced = 1'b0;                // [R17]
                     next_s.ph      = PH_CMD;
                  end else begin
                     next_s.ph = s.reduced ? PH_TX : PH_CMD;  // [R18]
                  end
               end else begin
                  next_s.st = D_IDLE;
                  // a sent one bit only counts when the host released early
                  bit_ok = (s.ph != PH_TX) | ~s.tx[s.bitn] | s.seen_rise;  // [R12]
               end
            end
         end
         D_PWAIT: begin
            next_s.cnt = s.cnt + 16'd1;
            if (s.cnt >= `OW_PRES_WAIT_CYC - 16'd1) begin
               next_s.st  = D_PDRIVE;                      // [R04]
               next_s.cnt = 16'd0;
               next_s.oe  = 1'b1;
            end
         end
         D_PDRIVE: begin
            next_s.cnt = s.cnt + 16'd1;
            if (s.cnt >= PRES_LOW_CYC - 16'd1) begin
               next_s.st = D_IDLE;                         // [R04]
               next_s.oe = 1'b0;
            end
         end
         default: begin
            next_s.st = D_IDLE;
            next_s.oe = 1'b0;
         end
      endcase

      // bit and byte bookkeeping
      if (bit_ok) begin
         next_s.fresh = 1'b0;
         next_s.bitn  = s.bitn + 3'd1;
         if (s.bitn == 3'd7) begin
            case (s.ph)
               PH_CMD: begin
                  // parameter bytes after a command are not checked here
                  case (rbyte)
                     `OW_CMD_CLEAR: next_s.clr = 1'b1;     // [R14] [R13]
                     `OW_CMD_RESET: begin
                        next_s.mrst    = 1'b1;             // [R14]
                        next_s.reduced = 1'b0;
                     end
                     `OW_CMD_READ: begin
                        next_s.ph      = PH_REG;           // [R14]
                        next_s.reduced = 1'b0;             // [R17]
                     end
                     `OW_CMD_BARE: begin
                        next_s.ph      = PH_TX;            // [R16]
                        next_s.reduced = 1'b1;
                     end
                     default: next_s.ph = PH_CMD;
                  endcase
               end
               PH_REG: begin
                  // out-of-range pointer falls back to the first address
                  if (rbyte >= `OW_INST_FLOW_BYTE0 && rbyte <= `OW_TOTAL_FLOW_CHECK) begin
                     next_s.ptr = rbyte;                   // [R15]
                  end else begin
                     next_s.ptr = `OW_INST_FLOW_BYTE0;     // [R15]
                  end
                  next_s.ph = PH_TX;
               end
               PH_TX: begin
                  next_s.ptr = (s.ptr == `OW_TOTAL_FLOW_CHECK) ?
                               `OW_INST_FLOW_BYTE0 : s.ptr + 8'd1;  // [R15]
               end
               default: next_s.ph = PH_CMD;
            endcase
         end
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         s      <= '0;
         s.st   <= D_IDLE;
         s.ph   <= PH_CMD;
         s.ptr  <= `OW_INST_FLOW_BYTE0;
         s.dq_q <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign link.dev_oe  = s.oe;
   assign CLEAR_TOTAL  = s.clr;
   assign MODULE_RESET = s.mrst;
   assign REDUCED_MODE = s.reduced;

endmodule // ow_flow_device

// ---- hdl/ow_host_ctrl.sv ----
// host end of the single-wire flow link, ordered over apb
`timescale 1ns/10ps
`include "ow_link_regs.svh"
module ow_host_ctrl
   import ow_link_pkg::*;
#(
   parameter logic [15:0] HOST_RST_CYC = `OW_HOST_RST_CYC
) (
   input  wire logic        MCLK,
   input  wire logic        RST_N,
   ow_link_if.host          link,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR
);

   host_reg_t s;
   host_reg_t next_s;
   logic      busy;

   assign busy = (s.st != H_IDLE);

   // ==========================================================
   // apb slave and link engine
   always_comb begin
      next_s = s;
      // setup cycle prepares the answer so the access phase is one cycle
      if (PSEL && !PENABLE) begin
         next_s.pready  = 1'b1;
         next_s.pslverr = 1'b0;
         next_s.prdata  = 32'h0000_0000;
         case (PADDR)
            `OW_APB_CMD: next_s.prdata = 32'h0000_0000;
            `OW_APB_STATUS: begin
               next_s.prdata[`OW_STAT_BUSY_BIT] = busy;
               next_s.prdata[`OW_STAT_PRES_BIT] = s.presence;
            end
            `OW_APB_RXDATA: next_s.prdata[7:0] = s.rxd;
            default: next_s.pslverr = 1'b1;
         endcase
      end else if (PSEL && PENABLE && s.pready) begin
         next_s.pready  = 1'b0;
         next_s.pslverr = 1'b0;
      end
      // an order written while busy is dropped
      if (PSEL && PENABLE && s.pready && PWRITE && PADDR == `OW_APB_CMD && !busy) begin
         next_s.op   = host_op_t'(PWDATA[`OW_CMD_OP_LSB +: 2]);
         next_s.sh   = PWDATA[`OW_CMD_DATA_LSB +: 8];
         next_s.cnt  = 16'd0;
         next_s.bitn = 3'd0;
         case (host_op_t'(PWDATA[`OW_CMD_OP_LSB +: 2]))
            OP_RESET: begin
               next_s.st       = H_RST_LOW;
               next_s.oe       = 1'b1;              // [R24]
               next_s.presence = 1'b0;
            end
            OP_WRITE, OP_READ: begin
               next_s.st = H_SLOT;
               next_s.oe = 1'b1;
            end
            default: next_s.st = H_IDLE;
         endcase
      end

      case (s.st)
         H_IDLE: begin
         end
         H_RST_LOW: begin
            next_s.cnt = s.cnt + 16'd1;
            if (s.cnt >= HOST_RST_CYC - 16'd1) begin
               next_s.st  = H_RST_WAIT;
               next_s.oe  = 1'b0;
               next_s.cnt = 16'd0;
            end
         end
         H_RST_WAIT: begin
            next_s.cnt = s.cnt + 16'd1;
            // sample the presence pulse inside the device's low window
            if (s.cnt == `OW_HOST_PRES_CYC) begin
               next_s.presence = ~link.dq;          // [R04]
            end
            if (s.cnt >= HOST_RST_CYC - 16'd1) begin
               next_s.st = H_IDLE;
            end
         end
         H_SLOT: begin
            next_s.cnt = s.cnt + 16'd1;
            if (s.op == OP_WRITE) begin
               // zero holds low to the slot end, one releases after 3 us
               if (s.sh[0] && s.cnt >= `OW_WR_LOW_CYC - 16'd1) begin
                  next_s.oe = 1'b0;                 // [R06] [R01]
               end
            end else begin
               if (s.cnt >= `OW_RD_LOW_CYC - 16'd1) begin
                  next_s.oe = 1'b0;                 // [R09]
               end
               if (s.cnt == `OW_RD_SAMPLE_CYC) begin
                  next_s.rxd = {link.dq, s.rxd[7:1]};  // [R09] [R01]
               end
            end
            if (s.cnt >= `OW_SLOT_CYC - 16'd1) begin
               next_s.st  = H_GAP;                  // [R05] [R10]
               next_s.oe  = 1'b0;
               next_s.cnt = 16'd0;
            end
         end
         H_GAP: begin
            next_s.cnt = s.cnt + 16'd1;
            // recovery of 2 us keeps clear of the 1 us minimum
            if (s.cnt >= `OW_GAP_CYC - 16'd1) begin
               next_s.cnt  = 16'd0;
               next_s.bitn = s.bitn + 3'd1;
               next_s.sh   = {1'b0, s.sh[7:1]};     // [R01]
               if (s.bitn == 3'd7) begin
                  next_s.st = H_IDLE;
               end else begin
                  next_s.st = H_SLOT;               // [R05] [R10]
                  next_s.oe = 1'b1;
               end
            end
         end
         default: begin
            next_s.st = H_IDLE;
            next_s.oe = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // registers
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         s    <= '0;
         s.st <= H_IDLE;
         s.op <= OP_NONE;
      end else begin
         s <= next_s;
      end
   end

   assign link.host_oe = s.oe;
   assign PRDATA       = s.prdata;
   assign PREADY       = s.pready;
   assign PSLVERR      = s.pslverr;

endmodule // ow_host_ctrl

// ---- sim/ow_link_chk.sv ----
// checker of the single wire between host and device ends
`timescale 1ns/10ps
module ow_link_chk #(
   parameter logic [15:0] BUS_RST_CYC  = 16'd16000,
   parameter logic [15:0] PRES_LOW_CYC = 16'd4800
) (
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic host_oe,
   input wire logic dev_oe,
   input wire logic dq
);
   logic [15:0] hlow;
   logic [15:0] hhi;
   logic [15:0] srise;
   logic [15:0] dcnt;
   logic        hq;
   logic        arm;

   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_N);

   // ==========================================================
   // run lengths of each line state, saturating so idle cannot wrap
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         hlow <= 16'h0000;
         hhi <= 16'hffff;
         srise <= 16'hffff;
         dcnt <= 16'h0000;
         hq <= 1'b0;
         arm <= 1'b0;
      end else begin
         hlow <= host_oe ? hlow + {15'h0, ~&hlow} : 16'h0000;
         hhi <= host_oe ? 16'h0000 : hhi + {15'h0, ~&hhi};
         srise <= (host_oe && !hq) ? 16'h0000 : srise + {15'h0, ~&srise};
         dcnt <= dev_oe ? dcnt + {15'h0, ~&dcnt} : 16'h0000;
         hq <= host_oe;
         // armed from a bus reset release until the host starts a slot
         arm <= (hq && !host_oe && hlow >= BUS_RST_CYC) ? 1'b1 : (host_oe ? 1'b0 : arm);
      end
   end

   // ==========================================================
   // device end
   // hhi counts from the reset release, so 2400 low-free cycles is the 60 us limit
   pres_delay_a:
      assert property (arm && hhi == 16'd2400 |-> dev_oe)
         else $error("presence pulse not started in time");
   pres_quiet_a:
      assert property (arm && hhi < 16'd600 |-> !dev_oe)
         else $error("presence pulse too early");
   pres_len_a:
      assert property (arm && $fell(dev_oe) |-> dcnt >= 16'd2400 && dcnt <= 16'd9600
                       && dcnt + 16'd1 >= PRES_LOW_CYC && dcnt <= PRES_LOW_CYC + 16'd1)
         else $error("presence pulse length wrong");
   rst_quiet_a:
      assert property (host_oe && hlow > 16'd2500 |-> !dev_oe)
         else $error("device drives during host reset");
   slot_start_a:
      assert property ($rose(dev_oe) && !arm |-> $past(host_oe) || $past(host_oe, 2))
         else $error("device drive not tied to a slot start");
   slot_hold_a:
      assert property ($fell(dev_oe) && !arm |-> dcnt >= 16'd2360 && dcnt <= 16'd2400)
         else $error("read slot drive length wrong");

   // ==========================================================
   // host end
   host_low_a:
      assert property ($fell(host_oe) |-> (hlow >= 16'd40 && hlow <= 16'd600) || hlow >= 16'd2400)
         else $error("host low time out of range");
   host_gap_a:
      assert property ($rose(host_oe) |-> hhi > 16'd40 && srise >= 16'd2440)
         else $error("host slot too short or gap missing");

   cover property (arm && $fell(dev_oe));
   cover property (!arm && $fell(dev_oe));
   cover property ($fell(host_oe) && hlow >= 16'd2400 && hlow < BUS_RST_CYC);
endmodule // ow_link_chk

// ---- sim/tb.sv ----
// self-checking bench: host and device ends joined, host ordered over apb
`timescale 1ns/10ps
module tb;
   // ==========================================================
   // shortened counts; device reset threshold stays above a zero slot
   localparam logic [15:0] HOST_RST = 16'd4000;
   localparam logic [15:0] BUS_RST  = 16'd3200;
   localparam logic [15:0] PRES_LOW = 16'd2800;
   logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, wsh;
   logic [31:0] pwdata, prdata, r;
   logic [23:0] flow, temp, total;
   logic        ready, clr, mrst, red, e;
   int          failures, n_compared, seed, n_clr, n_mrst;

   ow_link_if lnk ();
   ow_flow_device #(.BUS_RST_CYC(BUS_RST), .PRES_LOW_CYC(PRES_LOW)) u_ow_flow_device (
      .MCLK(mclk), .RST_N(rst_n), .link(lnk), .FLOW_RATE(flow), .WATER_TEMP(temp),
      .TOTAL_FLOW(total), .DATA_READY(ready), .CLEAR_TOTAL(clr), .MODULE_RESET(mrst),
      .REDUCED_MODE(red));
   ow_host_ctrl #(.HOST_RST_CYC(HOST_RST)) u_ow_host_ctrl (
      .MCLK(mclk), .RST_N(rst_n), .link(lnk), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr));
   ow_link_chk #(.BUS_RST_CYC(BUS_RST), .PRES_LOW_CYC(PRES_LOW)) u_ow_link_chk (
      .MCLK(mclk), .RST_N(rst_n), .host_oe(lnk.host_oe), .dev_oe(lnk.dev_oe), .dq(lnk.dq));

   // ==========================================================
   // clock, 25 ns period
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // wire monitor: level 20 us after each fall, shifted in lsb first
   initial begin
      wsh = 8'h00;
      forever begin
         @(negedge lnk.dq);
         repeat (800) @(negedge mclk);
         wsh = {lnk.dq, wsh[7:1]};
      end
   end

   // pulse counters; a pulse counts once for every cycle it is high
   always @(posedge mclk) begin
      n_clr <= n_clr + int'(clr === 1'b1);
      n_mrst <= n_mrst + int'(mrst === 1'b1);
   end

   // whole run needs about 3.2 ms; cut a hang at 5 ms
   initial begin
      #5000000;
      failures++;
      conclude();
   end

   // ==========================================================
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one transfer; idle cycle first so no signal is assigned twice in a step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // ready seen at a rising edge before the slave updates it; if it never comes only the watchdog ends this
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // order a link operation, then poll status until idle
   task automatic op(input logic [1:0] o, input logic [7:0] b);
      apb(1'b1, 8'h00, {16'h0, b, 6'h0, o});
      do begin
         apb(1'b0, 8'h04, 32'h0);
      end while (r[0] === 1'b1);
   endtask

   // expected result byte: data bytes low first, check byte over three below
   function automatic logic [7:0] mapb(input logic [7:0] a);
      logic [23:0] d;
      logic [7:0]  c;
      d = (a < 8'h34) ? flow : ((a < 8'h38) ? temp : total);
      c = 8'hff;
      for (int i = 0; i < 3; i++) begin
         c = c ^ d[8*i +: 8];
         for (int t = 0; t < 8; t++) begin
            c = c[7] ? ({c[6:0], 1'b0} ^ 8'h31) : {c[6:0], 1'b0};
         end
      end
      if (!ready) return 8'h00;
      return (a[1:0] == 2'd3) ? c : d[8*a[1:0] +: 8];
   endfunction

   task automatic rd(input logic [7:0] a);
      op(2'd3, 8'h00);
      apb(1'b0, 8'h08, 32'h0);
      check({24'h0, r[7:0]}, {24'h0, mapb(a)});
   endtask

   task automatic conclude();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ==========================================================
   initial begin
      seed = 84563;
      failures = 0;
      n_compared = 0;
      n_clr = 0;
      n_mrst = 0;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      flow = 24'h0;
      temp = 24'h0;
      total = 24'h0;
      ready = 1'b1;
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      flow <= 24'($random(seed));
      temp <= 24'($random(seed));
      total <= 24'hffffff;
      // unmapped place answers with an error and zero data
      apb(1'b0, 8'h0c, 32'($random(seed)));
      check({31'h0, e}, 32'h1);
      check(r, 32'h0);
      op(2'd1, 8'h00);
      check({31'h0, r[1]}, 32'h1);
      op(2'd2, 8'h5a);
      check({24'h0, wsh}, 32'h5a);
      check(32'(n_clr), 32'h1);
      op(2'd2, 8'h5d);
      check(32'(n_mrst), 32'h1);
      // pointer at the top of the map, so the second read wraps
      op(2'd2, 8'h5b);
      op(2'd2, 8'h3b);
      rd(8'h3b);
      rd(8'h30);
      check({31'h0, red}, 32'h0);
      conclude();
   end
endmodule // tb
